// ==== rtl/mt_pkg.sv ====
// Constants and types shared by the modulo timer and its tick generator.
// Assumes a single bus clock domain; register offsets are byte indices.
package mt_pkg;
  localparam int MT_AW = 3;
  localparam int MT_DW = 8;

  // Register offsets on the plain register port
  localparam logic [MT_AW-1:0] MT_OFS_STAT_CTRL = 3'h0;
  localparam logic [MT_AW-1:0] MT_OFS_CLK_CFG = 3'h1;
  localparam logic [MT_AW-1:0] MT_OFS_COUNT = 3'h2;
  localparam logic [MT_AW-1:0] MT_OFS_MODULO = 3'h3;
  localparam logic [MT_AW-1:0] MT_OFS_EVT_STAT = 3'h4;
  localparam logic [MT_AW-1:0] MT_OFS_EVT_MASK = 3'h5;

  // Field positions in the status/control register
  localparam int MT_BIT_FLAG = 7;
  localparam int MT_BIT_IRQ_EN = 6;
  localparam int MT_BIT_CLEAR = 5;
  localparam int MT_BIT_HALT = 4;
  // Field positions in the clock configuration register
  localparam int MT_SRC_LSB = 4;
  localparam int MT_PS_LSB = 0;

  // Values after reset
  localparam logic [7:0] MT_RST_COUNT = 8'h00;
  localparam logic [7:0] MT_RST_MODULO = 8'h00;
  localparam logic MT_RST_HALT = 1'b1;
  localparam logic [1:0] MT_RST_SRC = 2'h0;
  localparam logic [3:0] MT_RST_PS = 4'h0;
  localparam logic [7:0] MT_RST_PRESCALE = 8'h00;

  // Largest prescale code; larger codes behave as this one
  localparam logic [3:0] MT_PS_MAX = 4'h8;
  localparam logic [7:0] MT_COUNT_TOP = 8'hff;

  typedef enum logic [1:0] {
    MT_SRC_BUS = 2'b00,
    MT_SRC_FIXED = 2'b01,
    MT_SRC_EXT_FALL = 2'b10,
    MT_SRC_EXT_RISE = 2'b11
  } mt_src_t;
endpackage

// ==== rtl/mt_tick_gen.sv ====
// Source selection, pin synchronisers and power-of-two prescaler.
// Assumes both the tick pin and the fixed-rate reference are asynchronous.
`timescale 1ns/1ns
module mt_tick_gen
  import mt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic external_tick_input,
  input wire logic fixed_freq_ref_clock,
  mt_tick_if.gen tk
);
  typedef struct packed {
    logic [2:0] ext_m;
    logic ext_lvl;
    logic [2:0] fix_m;
    logic fix_lvl;
    logic [7:0] pre_cnt;
    logic tick;
  } mt_gen_st_t;

  mt_gen_st_t s_r;
  mt_gen_st_t s_nxt;
  logic src_edge;
  logic [3:0] ps_eff;
  logic [7:0] ps_mask;

  // Three-stage sync; a level counts once stages two and three agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.ext_m = {s_r.ext_m[1:0], external_tick_input};
    s_nxt.fix_m = {s_r.fix_m[1:0], fixed_freq_ref_clock};
    if (s_r.ext_m[1] == s_r.ext_m[2]) begin
      s_nxt.ext_lvl = s_r.ext_m[2];
    end
    if (s_r.fix_m[1] == s_r.fix_m[2]) begin
      s_nxt.fix_lvl = s_r.fix_m[2];
    end
    // Edge picked from the filtered level against the agreed stages
    case (tk.source_select)
      MT_SRC_BUS: src_edge = 1'b1;
      MT_SRC_FIXED: src_edge = s_nxt.fix_lvl & ~s_r.fix_lvl;
      MT_SRC_EXT_FALL: src_edge = ~s_nxt.ext_lvl & s_r.ext_lvl;
      MT_SRC_EXT_RISE: src_edge = s_nxt.ext_lvl & ~s_r.ext_lvl;
      default: src_edge = 1'b0;
    endcase
    // Codes above eight are treated as divide by 256
    ps_eff = (tk.prescale_select > MT_PS_MAX) ? MT_PS_MAX : tk.prescale_select;
    ps_mask = 8'((9'h001 << ps_eff) - 9'h001);
    s_nxt.tick = 1'b0;
    if (tk.clr) begin
      s_nxt.pre_cnt = MT_RST_PRESCALE;
    end else if (tk.run && src_edge) begin
      // Divide by two to the power of the select code
      s_nxt.pre_cnt = 8'(s_r.pre_cnt + 8'h01);
      s_nxt.tick = ((s_r.pre_cnt & ps_mask) == ps_mask);
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tk.tick = s_r.tick;
endmodule

// ==== rtl/mt_tick_if.sv ====
// Carrier between the timer core and its tick generator.
// Assumes both ends sit on the same bus clock.
`timescale 1ns/1ns
interface mt_tick_if;
  import mt_pkg::*;
  logic run;
  logic clr;
  mt_src_t source_select;
  logic [3:0] prescale_select;
  logic tick;

  modport gen (
    input run,
    input clr,
    input source_select,
    input prescale_select,
    output tick
  );
  modport ctl (
    output run,
    output clr,
    output source_select,
    output prescale_select,
    input tick
  );
endinterface

// ==== rtl/mt_timer.sv ====
// Modulo timer: register file, 8-bit counter, overflow flag and interrupt.
// Assumes a one-clock register port and mode levels from the same clock.
`timescale 1ns/1ns
module mt_timer
  import mt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [MT_AW-1:0] reg_addr,
  input wire logic [MT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [MT_DW-1:0] reg_rdata,
  output logic irq,
  input wire logic stop_mode,
  input wire logic bdm_active,
  input wire logic external_tick_input,
  input wire logic fixed_freq_ref_clock
);

  // Whole core state in one record
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] modulo_value;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic counter_halt_bit;
    mt_src_t source_select;
    logic [3:0] prescale_select;
    logic flag_seen;
    logic evt_status;
    logic evt_mask;
    logic [7:0] rdata;
    logic irq;
  } mt_core_st_t;

  mt_core_st_t s_r;
  mt_core_st_t s_nxt;

  // Decoded bus accesses
  logic wr_sc;
  logic wr_clk;
  logic wr_mod;
  logic wr_evt_mask;
  logic rd_sc;
  logic rd_evt;
  logic clr_req;
  logic wrap;
  logic count_tick;
  logic flag_set;
  logic flag_clr;
  logic [7:0] rd_mux;

  mt_tick_if tk ();

  // Prescaler and source edges live in the helper
  mt_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .external_tick_input(external_tick_input),
    .fixed_freq_ref_clock(fixed_freq_ref_clock),
    .tk(tk)
  );

  // Counter runs only when not halted, not stopped and not in debug
  assign tk.run = ~s_r.counter_halt_bit & ~stop_mode & ~bdm_active;
  assign tk.clr = clr_req;
  assign tk.source_select = s_r.source_select;
  assign tk.prescale_select = s_r.prescale_select;

  // Register decode; writes to the count register are ignored
  always_comb begin
    wr_sc = reg_wr && (reg_addr == MT_OFS_STAT_CTRL);
    wr_clk = reg_wr && (reg_addr == MT_OFS_CLK_CFG);
    wr_mod = reg_wr && (reg_addr == MT_OFS_MODULO);
    wr_evt_mask = reg_wr && (reg_addr == MT_OFS_EVT_MASK);
    rd_sc = reg_rd && (reg_addr == MT_OFS_STAT_CTRL);
    rd_evt = reg_rd && (reg_addr == MT_OFS_EVT_STAT);
  end

  // Counter reset: clear bit written with one, or any modulo write
  always_comb begin
    clr_req = (wr_sc && reg_wdata[MT_BIT_CLEAR]) || wr_mod;
  end

  // Wrap at the limit, or at the top when the limit is zero
  always_comb begin
    count_tick = tk.tick & tk.run;
    if (s_r.modulo_value == MT_RST_MODULO) begin
      wrap = (s_r.count == MT_COUNT_TOP);
    end else begin
      wrap = (s_r.count == s_r.modulo_value);
    end
    flag_set = count_tick & wrap;
  end

  // Flag clears after a read that saw it set and a zero written back
  always_comb begin
    flag_clr = clr_req;
    if (wr_sc && !reg_wdata[MT_BIT_FLAG] && s_r.flag_seen) begin
      flag_clr = 1'b1;
    end
  end

  // Read mux; unmapped offsets and write-only bits read zero
  always_comb begin
    case (reg_addr)
      MT_OFS_STAT_CTRL: begin
        rd_mux = 8'h00;
        rd_mux[MT_BIT_FLAG] = s_r.overflow_flag;
        rd_mux[MT_BIT_IRQ_EN] = s_r.overflow_irq_enable;
        rd_mux[MT_BIT_HALT] = s_r.counter_halt_bit;
      end
      MT_OFS_CLK_CFG: begin
        rd_mux = {2'b00, s_r.source_select, s_r.prescale_select};
      end
      MT_OFS_COUNT: begin
        rd_mux = s_r.count;
      end
      MT_OFS_MODULO: begin
        rd_mux = s_r.modulo_value;
      end
      MT_OFS_EVT_STAT: begin
        rd_mux = {7'h00, s_r.evt_status};
      end
      MT_OFS_EVT_MASK: begin
        rd_mux = {7'h00, s_r.evt_mask};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Next-state logic for the whole core
  always_comb begin
    s_nxt = s_r;

    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = reg_rd ? rd_mux : 8'h00;

    // Control fields; the flag bit itself is not writable as one
    if (wr_sc) begin
      s_nxt.overflow_irq_enable = reg_wdata[MT_BIT_IRQ_EN];
      s_nxt.counter_halt_bit = reg_wdata[MT_BIT_HALT];
    end

    // Source and prescale change without touching the count
    if (wr_clk) begin
      s_nxt.source_select = mt_src_t'(reg_wdata[MT_SRC_LSB +: 2]);
      s_nxt.prescale_select = reg_wdata[MT_PS_LSB +: 4];
    end

    if (wr_mod) begin
      s_nxt.modulo_value = reg_wdata;
    end

    // Counter: a clear beats a tick in the same cycle
    if (clr_req) begin
      s_nxt.count = MT_RST_COUNT;
    end else if (count_tick) begin
      s_nxt.count = wrap ? MT_RST_COUNT : 8'(s_r.count + 8'h01);
    end

    // Arm the clear sequence on a read that sees the flag set
    if (rd_sc && s_r.overflow_flag) begin
      s_nxt.flag_seen = 1'b1;
    end else if (wr_sc || !s_r.overflow_flag) begin
      s_nxt.flag_seen = 1'b0;
    end

    // Set wins over any clear, so a wrap is never lost
    if (flag_set) begin
      s_nxt.overflow_flag = 1'b1;
    end else if (flag_clr) begin
      s_nxt.overflow_flag = 1'b0;
    end

    // Sticky event copy, cleared by reading it; set still wins
    if (flag_set) begin
      s_nxt.evt_status = 1'b1;
    end else if (rd_evt) begin
      s_nxt.evt_status = 1'b0;
    end

    if (wr_evt_mask) begin
      s_nxt.evt_mask = reg_wdata[0];
    end

    // Interrupt is silenced in stop so it cannot act as a wake source
    s_nxt.irq = ~stop_mode &
      ((s_nxt.overflow_flag & s_nxt.overflow_irq_enable) |
       (s_nxt.evt_status & s_nxt.evt_mask));
  end

  // State register; reset by rst alone, stop only freezes the run term and masks irq
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r.count <= MT_RST_COUNT;
      s_r.modulo_value <= MT_RST_MODULO;
      s_r.overflow_flag <= 1'b0;
      s_r.overflow_irq_enable <= 1'b0;
      s_r.counter_halt_bit <= MT_RST_HALT;
      s_r.source_select <= MT_SRC_BUS;
      s_r.prescale_select <= MT_RST_PS;
      s_r.flag_seen <= 1'b0;
      s_r.evt_status <= 1'b0;
      s_r.evt_mask <= 1'b0;
      s_r.rdata <= 8'h00;
      s_r.irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register
  assign reg_rdata = s_r.rdata;
  assign irq = s_r.irq;

endmodule

// ==== sim/modulo_timer_8bit_tb.sv ====
// Self-checking bench for the modulo timer through its register port.
// Assumes mt_timer with its checker bound and a 100 MHz clock.
`timescale 1ns/1ns
module modulo_timer_8bit_tb;
  import mt_pkg::*;
  logic ref_clk, reg_wr, reg_rd, irq;
  logic rst = 1'b1;
  logic stop_mode = 1'b0;
  logic bdm_active = 1'b0;
  logic tick_pin = 1'b0;
  logic fix_pin = 1'b0;
  logic [MT_AW-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, c1, c2;
  int checks = 0;
  int mismatches = 0;
  int cycles = 0;
  int ps_exp = 0;

  mt_timer u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .stop_mode(stop_mode),
    .bdm_active(bdm_active), .external_tick_input(tick_pin), .fixed_freq_ref_clock(fix_pin));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Every signal is set at each edge, so no strobe is driven twice in one step
  task automatic op(input logic w, input logic r, input logic [MT_AW-1:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  task automatic wr(input logic [MT_AW-1:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  // Read data stands one cycle; sampled mid-cycle, away from either edge
  task automatic rdv(input logic [MT_AW-1:0] a, output logic [7:0] v);
    op(1'b0, 1'b1, a, 8'h00);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [MT_AW-1:0] a, input logic [7:0] e, input string n);
    logic [7:0] v;
    rdv(a, v);
    chk(n, v, e);
  endtask

  // Main sequence
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    idle(1);
    rd(MT_OFS_STAT_CTRL, 8'h10, "sc");
    rd(MT_OFS_CLK_CFG, 8'h00, "clk");
    rd(MT_OFS_COUNT, 8'h00, "cnt");
    rd(3'h6, 8'h00, "unmapped");
    $display("test reset values done");
    // Overflow: event path masked, then unmasked, then flag path
    wr(MT_OFS_MODULO, 8'h02);
    rd(MT_OFS_MODULO, 8'h02, "mod");
    wr(MT_OFS_COUNT, 8'h55);
    rd(MT_OFS_COUNT, 8'h00, "cnt ro");
    wr(MT_OFS_STAT_CTRL, 8'h00);
    idle(10);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(MT_OFS_EVT_MASK, 8'h01);
    idle(2);
    chk("irq event", {7'h00, irq}, 8'h01);
    wr(MT_OFS_STAT_CTRL, 8'h10);
    idle(3);
    rd(MT_OFS_EVT_STAT, 8'h01, "evt");
    rd(MT_OFS_EVT_STAT, 8'h00, "evt cleared");
    chk("irq off", {7'h00, irq}, 8'h00);
    wr(MT_OFS_STAT_CTRL, 8'h50);
    idle(2);
    chk("irq flag", {7'h00, irq}, 8'h01);
    rd(MT_OFS_STAT_CTRL, 8'hd0, "sc flag");
    wr(MT_OFS_STAT_CTRL, 8'h50);
    idle(2);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    rd(MT_OFS_STAT_CTRL, 8'h50, "sc cleared");
    $display("test overflow interrupt done");
    // Counter clear by clear bit and by modulo write
    // Clear lands two ticks after a wrap, so no flag set meets it
    wr(MT_OFS_STAT_CTRL, 8'h00);
    idle(4);
    wr(MT_OFS_STAT_CTRL, 8'h30);
    rd(MT_OFS_COUNT, 8'h00, "clr bit");
    rd(MT_OFS_STAT_CTRL, 8'h10, "sc clr");
    // Count moves off zero first, so the modulo write has work to do
    wr(MT_OFS_STAT_CTRL, 8'h00);
    idle(2);
    wr(MT_OFS_MODULO, 8'hc8);
    rd(MT_OFS_COUNT, 8'h00, "mod write");
    $display("test counter clear done");
    // Debug then stop freeze the count; stop also holds irq low
    wr(MT_OFS_STAT_CTRL, 8'h40);
    idle(210);
    for (int m = 0; m < 2; m++) begin
      stop_mode <= (m == 1);
      bdm_active <= (m == 0);
      idle(3);
      rdv(MT_OFS_COUNT, c1);
      rd(MT_OFS_COUNT, c1, "frozen");
      if (m == 1) chk("stop irq", {7'h00, irq}, 8'h00);
      stop_mode <= 1'b0;
      bdm_active <= 1'b0;
      idle(6);
      rdv(MT_OFS_COUNT, c2);
      chk("resumed", {7'h00, c2 == c1}, 8'h00);
    end
    $display("test freeze done");
    // Prescale ratios; a half tick of margin absorbs start latency
    // Code nine checks that codes above eight divide by 256
    for (int p = 4; p <= 9; p++) begin
      ps_exp = (p > 8) ? 8 : p;
      wr(MT_OFS_STAT_CTRL, 8'h30);
      wr(MT_OFS_CLK_CFG, 8'(p));
      rd(MT_OFS_CLK_CFG, 8'(p), "ps");
      wr(MT_OFS_STAT_CTRL, 8'h00);
      idle((1 << ps_exp) * 4 + (1 << (ps_exp - 1)));
      wr(MT_OFS_STAT_CTRL, 8'h10);
      rd(MT_OFS_COUNT, 8'h04, "prescaled");
    end
    // Pin sources: five pulses at an eighth of the bus rate
    for (int s = 1; s <= 3; s++) begin
      wr(MT_OFS_STAT_CTRL, 8'h30);
      wr(MT_OFS_CLK_CFG, 8'(s << 4));
      rd(MT_OFS_CLK_CFG, 8'(s << 4), "src");
      wr(MT_OFS_STAT_CTRL, 8'h00);
      repeat (5) begin
        tick_pin <= 1'b1;
        fix_pin <= 1'b1;
        idle(4);
        tick_pin <= 1'b0;
        fix_pin <= 1'b0;
        idle(4);
      end
      idle(6);
      wr(MT_OFS_STAT_CTRL, 8'h10);
      rd(MT_OFS_COUNT, 8'h05, "pin src");
    end
    $display("test clock sources done");
    // Leaving stop through reset restores reset state
    wr(MT_OFS_STAT_CTRL, 8'h40);
    stop_mode <= 1'b1;
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    stop_mode <= 1'b0;
    idle(1);
    rd(MT_OFS_STAT_CTRL, 8'h10, "sc after reset");
    rd(MT_OFS_MODULO, 8'h00, "mod after reset");
    $display("test stop reset done");
    finish_test();
  end
endmodule

// ==== sim/mt_timer_chk.sv ====
// Concurrent checks on the timer register port and interrupt output.
// Assumes it is bound to mt_timer: one clock, reset active high.
`timescale 1ns/1ns
module mt_timer_chk
  import mt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [MT_AW-1:0] reg_addr,
  input wire logic [MT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [MT_DW-1:0] reg_rdata,
  input wire logic irq,
  input wire logic stop_mode,
  input wire logic bdm_active,
  input wire logic external_tick_input,
  input wire logic fixed_freq_ref_clock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Counting is frozen in stop or debug
  wire frz = stop_mode | bdm_active;
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  // Counter reset: clear bit written or any modulo write
  sequence s_clr;
    reg_wr && (reg_addr == MT_OFS_MODULO || (reg_addr == MT_OFS_STAT_CTRL && reg_wdata[5]));
  endsequence
  property p_idle_zero;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
  property p_unmapped;
    reg_rd && reg_addr > MT_OFS_EVT_MASK |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sc_zero;
    s_rd(MT_OFS_STAT_CTRL) |=> reg_rdata[5] == 1'b0 && reg_rdata[3:0] == 4'h0;
  endproperty
  a_sc_zero: assert property (p_sc_zero) else $error("clear bit or spare bits read one");
  property p_clk_zero;
    s_rd(MT_OFS_CLK_CFG) |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_clk_zero: assert property (p_clk_zero) else $error("clock config spare bits set");
  property p_mod_back;
    s_wr(MT_OFS_MODULO) ##1 s_rd(MT_OFS_MODULO) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_mod_back: assert property (p_mod_back) else $error("modulo readback wrong");
  property p_clk_back;
    s_wr(MT_OFS_CLK_CFG) ##1 s_rd(MT_OFS_CLK_CFG) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f);
  endproperty
  a_clk_back: assert property (p_clk_back) else $error("clock config readback wrong");
  property p_clr_count;
    s_clr ##1 s_rd(MT_OFS_COUNT) |=> reg_rdata == 8'h00;
  endproperty
  a_clr_count: assert property (p_clr_count) else $error("count not zero after clear");
  property p_frozen;
    reg_rd && reg_addr == MT_OFS_COUNT && frz && $past(frz) ##2
      reg_rd && reg_addr == MT_OFS_COUNT && frz |=> reg_rdata == $past(reg_rdata, 2);
  endproperty
  a_frozen: assert property (p_frozen) else $error("count moved while frozen");
  property p_stop_irq;
    stop_mode |=> !irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("interrupt raised in stop");
endmodule

bind mt_timer mt_timer_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .stop_mode(stop_mode), .bdm_active(bdm_active), .external_tick_input(external_tick_input),
  .fixed_freq_ref_clock(fixed_freq_ref_clock));
